// [common/lpc_defs.vh]
// Constants for the loop-through output control register bank.
// Assumes an 8-bit register port addressed by byte offset.
`ifndef LPC_DEFS_VH
`define LPC_DEFS_VH

// Register offsets
`define LPC_ADDR_SELA 8'h52
`define LPC_ADDR_ENABLE 8'h56
`define LPC_ADDR_SELB 8'h57
`define LPC_ADDR_POWER 8'h63
`define LPC_ADDR_PATGEN 8'h64

// Field positions
`define LPC_BIT_SELA 7
`define LPC_BIT_DRIVE_ON 3
`define LPC_SELB_HI 2
`define LPC_SELB_LO 1
`define LPC_BIT_PWDN 0
`define LPC_BIT_PG_ON 0

// Selector codes
`define LPC_SELB_RX_PORT_ZERO 2'b01
`define LPC_SELB_RX_PORT_ONE 2'b10

// Reset values
`define LPC_RST_SELA 1'b0
`define LPC_RST_DRIVE_ON 1'b0
`define LPC_RST_SELB 2'b00
`define LPC_RST_PWDN 1'b0
`define LPC_RST_PATGEN 8'h10

// Synchroniser depth
`define LPC_SYNC_STAGES 2

`endif

// [core/lpc_sync.v]
// Two-flop synchroniser for a bundle of levels from outside the clock domain.
// Assumes the inputs are quasi-static or slow against the system clock.
`timescale 1ns/1ns
module lpc_sync #(
  parameter WIDTH = 2
) (
  input wire i_clk,
  input wire i_rst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  // First stage, read only by the second stage
  reg [WIDTH-1:0] meta_q;
  // Second stage, safe for logic
  reg [WIDTH-1:0] sync_q;

  // Both stages clear on reset to a constant
  always @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule

// [core/lpc_top.v]
// Loop-through output control: register bank and output steering.
// Assumes the serial data bits arrive from another domain and are sampled here.
// Assumes software keeps the two port selectors agreeing; a flag shows when not.
// Power-down and pattern enable leave here as levels, and power-down also stops
// forwarding here; the circuits that they switch sit outside this block.
//
// Contract
// - Enable bit switches loop-through driver on
// - Code 01 picks input 0, 10 input 1
// - Data appears only while driver enabled
// - Power-down bit turns loop-through transmitter off
// - Companion bit zero picks input 0, one input 1 (here only stored and compared; the main selector alone steers)
// - Pattern control bit zero enables generator
`timescale 1ns/1ns
`include "lpc_defs.vh"
module lpc_top (
  input wire I_CLK,
  input wire I_RST,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [7:0] O_RDATA,
  input wire I_SERIAL_IN_0,
  input wire I_SERIAL_IN_1,
  output reg O_LOOPTHROUGH_OUT,
  output reg O_LOOPTHROUGH_OUT_VALID,
  output reg O_LOOP_TX_POWERDOWN,
  output reg O_PATTERN_GEN_ON,
  output reg [6:0] O_PATTERN_CFG,
  output reg O_SEL_MISMATCH
);
  // Register fields
  // Companion selector, bit 7 at 0x52
  reg loop_port_pick_a_q;
  // Loop-through driver enable, bit 3 at 0x56
  reg loopthrough_drive_on_q;
  // Main selector, bits 2:1 at 0x57
  reg [1:0] loop_port_pick_b_q;
  // Transmitter power-down, bit 0 at 0x63
  reg loop_tx_powerdown_q;
  // Whole pattern-generator control byte at 0x64
  reg [7:0] test_pattern_control_q;
  // Read mux result, registered onto the bus one cycle later
  reg [7:0] rdata_d;

  // Synchronised serial inputs: bit 0 is input 0, bit 1 is input 1
  wire [1:0] serial_sync;
  // Steering decisions
  // High when the main selector names a real port
  reg pick_valid;
  // Synchronised bit of the named port, zero otherwise
  reg pick_bit;

  // Decode an address match; used by both write and read paths
  // A function so that the write and read decoders can never drift apart
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  // One synchroniser for both inputs; each is an independent level, so a
  // cycle of skew between them does no harm
  lpc_sync #(
    .WIDTH(2)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_RST),
    .i_async({I_SERIAL_IN_1, I_SERIAL_IN_0}),
    .o_sync(serial_sync)
  );

  // Register writes; reserved bits are not stored
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      // The driver comes up off and the transmitter powered, with no port named
      loop_port_pick_a_q <= `LPC_RST_SELA;
      loopthrough_drive_on_q <= `LPC_RST_DRIVE_ON;
      loop_port_pick_b_q <= `LPC_RST_SELB;
      loop_tx_powerdown_q <= `LPC_RST_PWDN;
      // Only the pattern register resets to a value other than zero
      test_pattern_control_q <= `LPC_RST_PATGEN;
    end
    else if (I_WR)
    begin
      if (hit(I_ADDR, `LPC_ADDR_SELA))
      begin
        // Stored for readback and for the disagreement flag only
        loop_port_pick_a_q <= I_WDATA[`LPC_BIT_SELA];
      end
      else if (hit(I_ADDR, `LPC_ADDR_ENABLE))
      begin
        loopthrough_drive_on_q <= I_WDATA[`LPC_BIT_DRIVE_ON];
      end
      else if (hit(I_ADDR, `LPC_ADDR_SELB))
      begin
        loop_port_pick_b_q <= I_WDATA[`LPC_SELB_HI:`LPC_SELB_LO];
      end
      else if (hit(I_ADDR, `LPC_ADDR_POWER))
      begin
        loop_tx_powerdown_q <= I_WDATA[`LPC_BIT_PWDN];
      end
      else if (hit(I_ADDR, `LPC_ADDR_PATGEN))
      begin
        // The ordering against power-down is software's job, not checked here;
        // refusing the write would leave software unable to read back its mistake
        test_pattern_control_q <= I_WDATA;
      end
    end
  end

  // Read mux; unmapped offsets and reserved bits read as zero
  always @*
  begin
    rdata_d = 8'h00;
    if (hit(I_ADDR, `LPC_ADDR_SELA))
    begin
      rdata_d[`LPC_BIT_SELA] = loop_port_pick_a_q;
    end
    else if (hit(I_ADDR, `LPC_ADDR_ENABLE))
    begin
      rdata_d[`LPC_BIT_DRIVE_ON] = loopthrough_drive_on_q;
    end
    else if (hit(I_ADDR, `LPC_ADDR_SELB))
    begin
      rdata_d[`LPC_SELB_HI:`LPC_SELB_LO] = loop_port_pick_b_q;
    end
    else if (hit(I_ADDR, `LPC_ADDR_POWER))
    begin
      rdata_d[`LPC_BIT_PWDN] = loop_tx_powerdown_q;
    end
    else if (hit(I_ADDR, `LPC_ADDR_PATGEN))
    begin
      // Every bit of the pattern register is read-write
      rdata_d = test_pattern_control_q;
    end
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_RDATA <= 8'h00;
    end
    else if (I_RD)
    begin
      O_RDATA <= rdata_d;
    end
    else
    begin
      // Back to zero so that stale data never looks like a fresh answer
      O_RDATA <= 8'h00;
    end
  end

  // Port steering from the two-bit selector
  always @*
  begin
    pick_valid = 1'b0;
    pick_bit = 1'b0;
    case (loop_port_pick_b_q)
      `LPC_SELB_RX_PORT_ZERO:
      begin
        pick_valid = 1'b1;
        pick_bit = serial_sync[0];
      end
      `LPC_SELB_RX_PORT_ONE:
      begin
        pick_valid = 1'b1;
        pick_bit = serial_sync[1];
      end
      default:
      begin
        // Codes 00 and 11 name no port, so nothing is forwarded
        pick_valid = 1'b0;
        pick_bit = 1'b0;
      end
    endcase
  end

  // Output stage; a powered-down transmitter also forwards nothing
  always @(posedge I_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      O_LOOPTHROUGH_OUT <= 1'b0;
      O_LOOPTHROUGH_OUT_VALID <= 1'b0;
      O_LOOP_TX_POWERDOWN <= 1'b0;
      O_PATTERN_GEN_ON <= 1'b0;
      O_PATTERN_CFG <= 7'h00;
      O_SEL_MISMATCH <= 1'b0;
    end
    else
    begin
      // Forward only while enabled, powered up and pointed at a port
      if (loopthrough_drive_on_q && pick_valid && !loop_tx_powerdown_q)
      begin
        O_LOOPTHROUGH_OUT <= pick_bit;
        O_LOOPTHROUGH_OUT_VALID <= 1'b1;
      end
      else
      begin
        O_LOOPTHROUGH_OUT <= 1'b0;
        O_LOOPTHROUGH_OUT_VALID <= 1'b0;
      end
      O_LOOP_TX_POWERDOWN <= loop_tx_powerdown_q;
      O_PATTERN_GEN_ON <= test_pattern_control_q[`LPC_BIT_PG_ON];
      // Remaining pattern bits go out untouched for the generator to decode
      O_PATTERN_CFG <= test_pattern_control_q[7:1];
      // Flags selectors that disagree, so software misconfiguration is visible.
      // The companion bit names input 1 when set, as code 10 does, so bit 1 of
      // the main selector is what it must equal; the data bits play no part.
      O_SEL_MISMATCH <= pick_valid
        && (loop_port_pick_a_q != loop_port_pick_b_q[1]);
    end
  end
endmodule

// [bench/lpc_partner.sv]
// Receiver model at the loop-through output.
// Assumes it samples the output on the system clock.
`timescale 1ns/1ns
module lpc_partner (
  input wire i_clk,
  input wire i_rst,
  input wire i_bit,
  input wire i_valid,
  output reg o_bit_q
);
  // Keep the last bit marked valid; idle bits are not data
  always @(posedge i_clk or posedge i_rst)
    if (i_rst)
      o_bit_q <= 1'b0;
    else if (i_valid)
      o_bit_q <= i_bit;
endmodule

// [bench/lpc_top_assertions.sv]
// Port checker for the loop-through control bank.
// Assumes one clock and the bind below.
`timescale 1ns/1ns
module lpc_top_chk (
  input wire I_CLK,
  input wire I_RST,
  input wire [7:0] I_ADDR,
  input wire [7:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [7:0] O_RDATA,
  input wire O_LOOPTHROUGH_OUT,
  input wire O_LOOPTHROUGH_OUT_VALID,
  input wire O_LOOP_TX_POWERDOWN,
  input wire O_PATTERN_GEN_ON
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  off_quiet_a:
    assert property (!O_LOOPTHROUGH_OUT_VALID |-> !O_LOOPTHROUGH_OUT)
      else $error("data while idle");
  pdown_blocks_a:
    assert property (O_LOOP_TX_POWERDOWN && $past(O_LOOP_TX_POWERDOWN)
      |-> !O_LOOPTHROUGH_OUT_VALID) else $error("forwarding while powered down");
  pdown_write_a:
    assert property (I_WR && I_ADDR == 8'h63 |-> ##2 O_LOOP_TX_POWERDOWN == $past(I_WDATA[0], 2))
      else $error("power-down not stored");
  pdown_hold_a:
    assert property (!I_WR && !$past(I_WR) |=> $stable(O_LOOP_TX_POWERDOWN))
      else $error("power-down moved");
  pgen_write_a:
    assert property (I_WR && I_ADDR == 8'h64 |-> ##2 O_PATTERN_GEN_ON == $past(I_WDATA[0], 2))
      else $error("pattern enable not stored");
  drive_off_a:
    assert property (I_WR && I_ADDR == 8'h56 && !I_WDATA[3] ##1 !(I_WR && I_ADDR == 8'h56)
      |=> !O_LOOPTHROUGH_OUT_VALID) else $error("driver still on");
  enable_rsvd_a:
    assert property (I_RD && I_ADDR == 8'h56 |=> (O_RDATA & 8'hf7) == 8'h00)
      else $error("reserved bits set");
endmodule
bind lpc_top lpc_top_chk i_lpc_top_chk (.I_CLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD,
  .O_RDATA, .O_LOOPTHROUGH_OUT, .O_LOOPTHROUGH_OUT_VALID, .O_LOOP_TX_POWERDOWN,
  .O_PATTERN_GEN_ON);

// [bench/test_lpc_top.sv]
// Self-checking bench for the loop-through control bank.
// Assumes the design and the receiver model are compiled first.
`timescale 1ns/1ns
module test_lpc_top;
  reg I_CLK = 0, I_RST = 1, I_WR = 0, I_RD = 0, I_SERIAL_IN_0 = 0, I_SERIAL_IN_1 = 0;
  reg [7:0] I_ADDR = 0, I_WDATA = 0;
  wire [7:0] O_RDATA;
  wire [6:0] O_PATTERN_CFG;
  wire O_LOOPTHROUGH_OUT, O_LOOPTHROUGH_OUT_VALID, O_LOOP_TX_POWERDOWN;
  wire O_PATTERN_GEN_ON, O_SEL_MISMATCH, seen_bit;
  // Status outputs gathered into one byte for the route and reset checks
  wire [7:0] loop_view = {4'h0, O_SEL_MISMATCH, O_LOOP_TX_POWERDOWN,
    O_LOOPTHROUGH_OUT_VALID, O_LOOPTHROUGH_OUT};
  integer failures = 0, compares = 0, k;
  reg [31:0] rows [0:5]; // Offset, write data, reset value, readback
  lpc_top i_lpc_top (.I_CLK, .I_RST, .I_ADDR, .I_WDATA, .I_WR, .I_RD, .O_RDATA,
    .I_SERIAL_IN_0, .I_SERIAL_IN_1, .O_LOOPTHROUGH_OUT, .O_LOOPTHROUGH_OUT_VALID,
    .O_LOOP_TX_POWERDOWN, .O_PATTERN_GEN_ON, .O_PATTERN_CFG, .O_SEL_MISMATCH);
  lpc_partner i_lpc_partner (.i_clk(I_CLK), .i_rst(I_RST), .i_bit(O_LOOPTHROUGH_OUT),
    .i_valid(O_LOOPTHROUGH_OUT_VALID), .o_bit_q(seen_bit));
  initial forever #2 I_CLK = ~I_CLK;
  task chk(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp)
    begin
      failures = failures + 1;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    @(posedge I_CLK);
    I_WR <= 1; I_ADDR <= a; I_WDATA <= d;
    @(posedge I_CLK);
    I_WR <= 0;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    @(posedge I_CLK);
    I_RD <= 1; I_ADDR <= a;
    @(posedge I_CLK);
    I_RD <= 0;
    #1 chk(O_RDATA, e);
  endtask
  // Program a route, drive both inputs, check after the sync latency
  task route(input [7:0] en, s, pd, input i0, i1, ev, eo);
    wr(8'h56, en);
    wr(8'h57, s);
    wr(8'h52, {s[2], 7'h0});
    wr(8'h63, pd);
    I_SERIAL_IN_0 <= i0; I_SERIAL_IN_1 <= i1;
    repeat (5) @(posedge I_CLK);
    #1 chk(loop_view, {5'h00, pd[0], ev, eo});
  endtask
  task final_report;
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog well beyond the fewer than two hundred cycles the tests need
  initial
  begin
    #40000 failures = failures + 1;
    final_report;
  end
  initial
  begin
    rows[0] = 32'h56ff0008; rows[1] = 32'h57ff0006; rows[2] = 32'h63ff0001;
    rows[3] = 32'h64ff10ff; rows[4] = 32'h52ff0080; rows[5] = 32'h10ff0000;
    repeat (8) @(posedge I_CLK);
    I_RST <= 0;
    @(posedge I_CLK);
    #1 chk({O_PATTERN_GEN_ON, O_PATTERN_CFG}, 8'h08);
    chk(loop_view, 8'h00);
    for (k = 0; k < 6; k = k + 1) rd(rows[k][31:24], rows[k][15:8]);
    // Power-down row precedes the pattern row
    for (k = 0; k < 6; k = k + 1)
    begin
      wr(rows[k][31:24], rows[k][23:16]);
      rd(rows[k][31:24], rows[k][7:0]);
    end
    chk({O_PATTERN_GEN_ON, O_PATTERN_CFG}, 8'hff);
    wr(8'h64, 8'h00);
    route(8'h08, 8'h02, 8'h00, 0, 1, 1, 0);
    route(8'h08, 8'h04, 8'h00, 1, 0, 1, 0);
    route(8'h08, 8'h02, 8'h00, 1, 0, 1, 1);
    route(8'h08, 8'h04, 8'h00, 0, 1, 1, 1);
    route(8'h08, 8'h06, 8'h00, 1, 1, 0, 0);
    route(8'h08, 8'h00, 8'h00, 1, 1, 0, 0);
    route(8'h00, 8'h02, 8'h00, 1, 1, 0, 0);
    route(8'h08, 8'h02, 8'h01, 1, 1, 0, 0);
    chk({7'h0, seen_bit}, 8'h01);
    // Disagreeing selectors raise the flag; a code naming no port clears it
    wr(8'h52, 8'h80);
    repeat (2) @(posedge I_CLK);
    #1 chk({7'h0, O_SEL_MISMATCH}, 8'h01);
    wr(8'h57, 8'h00);
    repeat (2) @(posedge I_CLK);
    #1 chk({7'h0, O_SEL_MISMATCH}, 8'h00);
    // A reset in mid-run must clear state that differs from its reset value
    @(posedge I_CLK);
    I_RST <= 1;
    @(posedge I_CLK);
    #1 chk(loop_view, 8'h00);
    @(posedge I_CLK);
    I_RST <= 0;
    rd(8'h52, 8'h00);
    rd(8'h63, 8'h00);
    rd(8'h64, 8'h10);
    final_report;
  end
endmodule
